//--- hw/spbs_pkg.sv
/*
 * Shared constants and types of the serial port control and bit-rate block.
 * Assumes one oscillator clock feeds the block; counts are in its cycles or in sixteenth-bit ticks.
 */
package spbs_pkg;
    // Register addresses on the byte-wide register port.
    localparam logic [7:0]  SPBS_ADDR_POWER_AND_RATE_CONTROL  = 8'h87;
    localparam logic [7:0]  SPBS_ADDR_TH1   = 8'h8D;
    localparam logic [7:0]  SPBS_ADDR_SERIAL_CONTROL_STATUS  = 8'h98;
    localparam logic [7:0]  SPBS_ADDR_SERIAL_BUFFER  = 8'h99;
    localparam logic [7:0]  SPBS_ADDR_TIMER2_CONTROL = 8'hC8;
    localparam logic [7:0]  SPBS_ADDR_TIMER2_RELOAD_LOW  = 8'hCA;
    localparam logic [7:0]  SPBS_ADDR_TIMER2_RELOAD_HIGH  = 8'hCB;
    // Field positions.
    localparam int          SPBS_SERIAL_CONTROL_STATUS_SM0   = 7;
    localparam int          SPBS_SERIAL_CONTROL_STATUS_SM1   = 6;
    localparam int          SPBS_SERIAL_CONTROL_STATUS_SM2   = 5;
    localparam int          SPBS_SERIAL_CONTROL_STATUS_REN   = 4;
    localparam int          SPBS_SERIAL_CONTROL_STATUS_TB8   = 3;
    localparam int          SPBS_SERIAL_CONTROL_STATUS_RB8   = 2;
    localparam int          SPBS_SERIAL_CONTROL_STATUS_TI    = 1;
    localparam int          SPBS_SERIAL_CONTROL_STATUS_RI    = 0;
    localparam int          SPBS_POWER_AND_RATE_CONTROL_RATE_DOUBLE_BIT  = 7;
    localparam int          SPBS_T2_RCLK    = 5;
    localparam int          SPBS_T2_TIMER2_TX_CLOCK_SELECT    = 4;
    localparam int          SPBS_T2_TR2     = 2;
    // Reset values.
    localparam logic [7:0]  SPBS_BYTE_RST   = 8'h00;
    localparam logic [15:0] SPBS_RC2_RST    = 16'h0000;
    // Timing counts in oscillator cycles or sixteenth-bit ticks.
    localparam logic [3:0]  SPBS_M0_LAST    = 4'hB;
    localparam logic [3:0]  SPBS_M0_HALF    = 4'h6;
    localparam logic [1:0]  SPBS_M2_SLOW    = 2'h3;
    localparam logic [1:0]  SPBS_M2_FAST    = 2'h1;
    localparam logic [7:0]  SPBS_T1_TOP     = 8'hFF;
    localparam logic [15:0] SPBS_T2_TOP     = 16'hFFFF;
    localparam logic [3:0]  SPBS_BIT_LAST   = 4'hF;
    localparam logic [3:0]  SPBS_SAMP_A     = 4'h7;
    localparam logic [3:0]  SPBS_SAMP_B     = 4'h8;
    localparam logic [3:0]  SPBS_SAMP_C     = 4'h9;
    localparam logic [2:0]  SPBS_DATA_LAST  = 3'h7;

    typedef enum logic [1:0] {
        SPBS_MODE_SHIFT = 2'b00,
        SPBS_MODE_8VAR  = 2'b01,
        SPBS_MODE_9FIX  = 2'b10,
        SPBS_MODE_9VAR  = 2'b11
    } spbs_mode_type;

    typedef enum logic [2:0] {
        SPBS_ST_IDLE  = 3'b000,
        SPBS_ST_START = 3'b001,
        SPBS_ST_DATA  = 3'b011,
        SPBS_ST_NINTH = 3'b010,
        SPBS_ST_STOP  = 3'b110
    } spbs_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } spbs_bus_req_type;
endpackage

//--- hw/spbs_top.sv
/*
 * Serial port control, status and bit-rate selection with its frame engines.
 * Assumes I_REF_CLK is the oscillator clock and the register master follows
 * the one-cycle strobe protocol; I_RXD is asynchronous and is synchronised.
 */
// Design decision made here: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// R1: Two mode bits pick one of four modes.
// R2: Nine-bit modes with filter drop ninth-bit-zero frames.
// R3: Eight-bit mode with filter needs valid stop.
// R4: Software keeps filter off in shift mode.
// R5: Reception runs only while receive enable set.
// R6: Nine-bit modes send software ninth bit.
// R7: Received ninth bit or stop bit stored.
// R8: Transmit flag at eighth bit or stop start.
// R9: Receive flag at eighth bit or mid stop.
// R10: Sixteen-times clock divided by sixteen per bit.
// R11: Doubling bit doubles fixed-mode and timer 1 rates; clear after reset.
// R12: Shift mode runs at oscillator over twelve.
// R13: Fixed mode runs oscillator over 64 or 32.
// R14: Variable modes use timer overflows.
// R15: Timer 1 rate times doubling over 32.
// R16: Software sets timer 1 as auto-reload.
// R17: Timer 2 select bits enable generator mode.
// R18: Timer 2 rollover reloads sixteen-bit preset.
// R19: Timer 2 overflow rate over sixteen.
// R20: Generator steps at half oscillator, no flag.
// R21: Buffer write starts transmit; reads receive register.
// R22: Each direction picks timer 2 or 1.
module spbs_top
    import spbs_pkg::*;
(
    // Clock and reset
    input  wire logic             I_REF_CLK,
    input  wire logic             I_RESET_N,
    // Register port
    input  wire spbs_bus_req_type I_BUS,
    output logic [7:0]            O_RDATA,
    // Serial pins
    input  wire logic             I_RXD,
    output logic                  O_RXD_OUT,
    output logic                  O_RXD_OE_N,
    output logic                  O_TXD,
    // Completion flags
    output logic                  O_TX_DONE,
    output logic                  O_RX_DONE
);
    function automatic logic is_nine(input spbs_mode_type m);
        return m[1];
    endfunction

    spbs_mode_type  mode_reg;
    spbs_state_type tx_state_reg, tx_state_next, rx_state_reg, rx_state_next;
    logic        sm2_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg;
    logic        rate_double_bit_reg, rclk_reg, timer2_tx_clock_select_reg, tr2_reg, st_reg, t1_half_reg;
    logic [7:0]  th1_reg, t1_cnt_reg, rbuf_reg, rdata_reg;
    logic [15:0] rc2_reg, t2_cnt_reg;
    logic [3:0]  m0_cnt_reg, tx_div_reg, rx_div_reg;
    logic [1:0]  m2_cnt_reg;
    logic [7:0]  tx_shift_reg, tx_shift_next, rx_shift_reg, rx_shift_next;
    logic [2:0]  tx_cnt_reg, tx_cnt_next, rx_cnt_reg, rx_cnt_next;
    logic        tx_pend_reg, tx_line_reg, tx_line_next, tx_done_set;
    logic        rx_ninth_reg, rx_ninth_next, rx_load;
    logic        rxd_meta_reg, rxd_sync_reg, rxd_prev_reg, s7_reg, s8_reg;
    logic        txd_reg, rxd_out_reg, rxd_oe_n_reg;

    // Register port decode.
    wire wr_serial_control_status  = I_BUS.wr && (I_BUS.addr == SPBS_ADDR_SERIAL_CONTROL_STATUS);
    wire wr_serial_buffer  = I_BUS.wr && (I_BUS.addr == SPBS_ADDR_SERIAL_BUFFER);
    wire wr_power_and_rate_control  = I_BUS.wr && (I_BUS.addr == SPBS_ADDR_POWER_AND_RATE_CONTROL);
    wire wr_timer2_control = I_BUS.wr && (I_BUS.addr == SPBS_ADDR_TIMER2_CONTROL);
    wire wr_th1   = I_BUS.wr && (I_BUS.addr == SPBS_ADDR_TH1);
    wire wr_timer2_reload_low  = I_BUS.wr && (I_BUS.addr == SPBS_ADDR_TIMER2_RELOAD_LOW);
    wire wr_timer2_reload_high  = I_BUS.wr && (I_BUS.addr == SPBS_ADDR_TIMER2_RELOAD_HIGH);
    wire [7:0] serial_control_status_val = {mode_reg, sm2_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg};
    wire [7:0] timer2_control_val = {2'b00, rclk_reg, timer2_tx_clock_select_reg, 1'b0, tr2_reg, 2'b00};
    wire [7:0] rd_val =
        (I_BUS.addr == SPBS_ADDR_SERIAL_CONTROL_STATUS)  ? serial_control_status_val :
        (I_BUS.addr == SPBS_ADDR_SERIAL_BUFFER)  ? rbuf_reg :                     // R21
        (I_BUS.addr == SPBS_ADDR_POWER_AND_RATE_CONTROL)  ? {rate_double_bit_reg, 7'h00} :
        (I_BUS.addr == SPBS_ADDR_TIMER2_CONTROL) ? timer2_control_val :
        (I_BUS.addr == SPBS_ADDR_TH1)   ? th1_reg :
        (I_BUS.addr == SPBS_ADDR_TIMER2_RELOAD_LOW)  ? rc2_reg[7:0] :
        (I_BUS.addr == SPBS_ADDR_TIMER2_RELOAD_HIGH)  ? rc2_reg[15:8] : SPBS_BYTE_RST;

    // Mode decode and bit-rate sources.
    wire       is_shift = (mode_reg == SPBS_MODE_SHIFT);                // R1
    wire       is_fixed = (mode_reg == SPBS_MODE_9FIX);                 // R1
    wire       m0_tick  = (m0_cnt_reg == SPBS_M0_LAST);                 // R12
    wire [3:0] m0_cnt_next = m0_tick ? 4'h0 : m0_cnt_reg + 4'h1;
    wire       m2_tick  = (m2_cnt_reg == (rate_double_bit_reg ? SPBS_M2_FAST : SPBS_M2_SLOW)); // R13 R11
    wire       t1_ovf   = m0_tick && (t1_cnt_reg == SPBS_T1_TOP);
    // Timer 1 overflow halved unless doubling is set, then split by 16.
    wire       t1_tick16 = t1_ovf && (rate_double_bit_reg || t1_half_reg);        // R15 R11
    wire       t2_run   = tr2_reg && (rclk_reg || timer2_tx_clock_select_reg);            // R17
    wire       t2_ovf   = t2_run && st_reg && (t2_cnt_reg == SPBS_T2_TOP); // R20
    wire       tx_tick16 = is_fixed ? m2_tick : (timer2_tx_clock_select_reg ? t2_ovf : t1_tick16); // R14 R22 R19
    wire       rx_tick16 = is_fixed ? m2_tick : (rclk_reg ? t2_ovf : t1_tick16); // R14 R22 R19
    wire       tx_bit   = tx_tick16 && (tx_div_reg == SPBS_BIT_LAST);   // R10
    wire       tx_step  = is_shift ? m0_tick : tx_bit;
    wire       rx_fall  = rxd_prev_reg && !rxd_sync_reg;
    wire       rx_decide = rx_tick16 && (rx_div_reg == SPBS_SAMP_C);    // R10
    wire       maj = (s7_reg & s8_reg) | (s7_reg & rxd_sync_reg) | (s8_reg & rxd_sync_reg);
    wire       rx_start = (rx_state_reg == SPBS_ST_IDLE) && ren_reg && !is_shift && rx_fall;
    wire       m0_busy = is_shift && ((tx_state_next != SPBS_ST_IDLE) ||
                                      (rx_state_next != SPBS_ST_IDLE));
    wire       sclk_next = !(m0_busy && (m0_cnt_next < SPBS_M0_HALF));
    wire       rb8_in = is_nine(mode_reg) ? rx_ninth_reg : maj;          // R7
    wire       rb8_load = rx_load && !is_shift;
    // Hardware sets win over a software clear in the same cycle.
    wire       ti_next = tx_done_set | (wr_serial_control_status ? I_BUS.wdata[SPBS_SERIAL_CONTROL_STATUS_TI] : ti_reg); // R8
    wire       ri_next = rx_load | (wr_serial_control_status ? I_BUS.wdata[SPBS_SERIAL_CONTROL_STATUS_RI] : ri_reg);     // R9

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_cnt_next   = tx_cnt_reg;
        tx_line_next  = tx_line_reg;
        tx_done_set   = 1'b0;
        if (tx_step) begin
            case (tx_state_reg)
                SPBS_ST_IDLE: if (tx_pend_reg) begin
                    tx_state_next = is_shift ? SPBS_ST_DATA : SPBS_ST_START;
                    tx_line_next  = is_shift ? tx_shift_reg[0] : 1'b0;
                    tx_shift_next = is_shift ? tx_shift_reg >> 1 : tx_shift_reg;
                    tx_cnt_next   = 3'h0;
                end
                SPBS_ST_START: begin
                    tx_state_next = SPBS_ST_DATA;
                    tx_line_next  = tx_shift_reg[0];
                    tx_shift_next = tx_shift_reg >> 1;
                end
                SPBS_ST_DATA: if (tx_cnt_reg != SPBS_DATA_LAST) begin
                    tx_line_next  = tx_shift_reg[0];
                    tx_shift_next = tx_shift_reg >> 1;
                    tx_cnt_next   = tx_cnt_reg + 3'h1;
                end else if (is_shift) begin
                    tx_state_next = SPBS_ST_IDLE;
                    tx_line_next  = 1'b1;
                    tx_done_set   = 1'b1;                               // R8
                end else if (is_nine(mode_reg)) begin
                    tx_state_next = SPBS_ST_NINTH;
                    tx_line_next  = tb8_reg;                            // R6
                end else begin
                    tx_state_next = SPBS_ST_STOP;
                    tx_line_next  = 1'b1;
                    tx_done_set   = 1'b1;                               // R8
                end
                SPBS_ST_NINTH: begin
                    tx_state_next = SPBS_ST_STOP;
                    tx_line_next  = 1'b1;
                    tx_done_set   = 1'b1;                               // R8
                end
                SPBS_ST_STOP: tx_state_next = SPBS_ST_IDLE;
                default: tx_state_next = SPBS_ST_IDLE;
            endcase
        end
    end

    always_comb begin
        rx_state_next = rx_state_reg;
        rx_shift_next = rx_shift_reg;
        rx_cnt_next   = rx_cnt_reg;
        rx_ninth_next = rx_ninth_reg;
        rx_load       = 1'b0;
        if (!ren_reg) begin
            rx_state_next = SPBS_ST_IDLE;                               // R5
        end else begin
            case (rx_state_reg)
                SPBS_ST_IDLE: if (is_shift ? (m0_tick && !ri_reg) : rx_fall) begin
                    rx_state_next = is_shift ? SPBS_ST_DATA : SPBS_ST_START;
                    rx_cnt_next   = 3'h0;
                end
                SPBS_ST_START: if (rx_decide) begin
                    // A start bit that does not vote low is treated as noise.
                    rx_state_next = maj ? SPBS_ST_IDLE : SPBS_ST_DATA;
                end
                SPBS_ST_DATA: if (is_shift) begin
                    if (m0_cnt_reg == SPBS_M0_HALF) begin
                        rx_shift_next = {rxd_sync_reg, rx_shift_reg[7:1]};
                    end
                    if (m0_tick && (rx_cnt_reg == SPBS_DATA_LAST)) begin
                        rx_state_next = SPBS_ST_IDLE;
                        rx_load       = 1'b1;                           // R9
                    end else if (m0_tick) begin
                        rx_cnt_next = rx_cnt_reg + 3'h1;
                    end
                end else if (rx_decide) begin
                    rx_shift_next = {maj, rx_shift_reg[7:1]};
                    rx_cnt_next   = rx_cnt_reg + 3'h1;
                    if (rx_cnt_reg == SPBS_DATA_LAST) begin
                        rx_state_next = is_nine(mode_reg) ? SPBS_ST_NINTH : SPBS_ST_STOP;
                    end
                end
                SPBS_ST_NINTH: if (rx_decide) begin
                    rx_ninth_next = maj;
                    rx_state_next = SPBS_ST_STOP;
                end
                SPBS_ST_STOP: if (rx_decide) begin
                    rx_state_next = SPBS_ST_IDLE;
                    rx_load = !ri_reg && (!sm2_reg || rb8_in);          // R2 R3 R9
                end
                default: rx_state_next = SPBS_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            mode_reg <= SPBS_MODE_SHIFT;
            {sm2_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg} <= SPBS_BYTE_RST[5:0];
            {rate_double_bit_reg, rclk_reg, timer2_tx_clock_select_reg, tr2_reg} <= SPBS_BYTE_RST[3:0];  // R11
            th1_reg <= SPBS_BYTE_RST;
            rc2_reg <= SPBS_RC2_RST;
        end else begin
            if (wr_serial_control_status) begin
                mode_reg <= spbs_mode_type'(I_BUS.wdata[SPBS_SERIAL_CONTROL_STATUS_SM0:SPBS_SERIAL_CONTROL_STATUS_SM1]);
                sm2_reg  <= I_BUS.wdata[SPBS_SERIAL_CONTROL_STATUS_SM2];
                ren_reg  <= I_BUS.wdata[SPBS_SERIAL_CONTROL_STATUS_REN];
                tb8_reg  <= I_BUS.wdata[SPBS_SERIAL_CONTROL_STATUS_TB8];
            end
            rb8_reg <= rb8_load ? rb8_in : (wr_serial_control_status ? I_BUS.wdata[SPBS_SERIAL_CONTROL_STATUS_RB8] : rb8_reg); // R7
            ti_reg  <= ti_next;
            ri_reg  <= ri_next;
            if (wr_power_and_rate_control) rate_double_bit_reg <= I_BUS.wdata[SPBS_POWER_AND_RATE_CONTROL_RATE_DOUBLE_BIT];
            if (wr_timer2_control) begin
                rclk_reg <= I_BUS.wdata[SPBS_T2_RCLK];
                timer2_tx_clock_select_reg <= I_BUS.wdata[SPBS_T2_TIMER2_TX_CLOCK_SELECT];
                tr2_reg  <= I_BUS.wdata[SPBS_T2_TR2];
            end
            if (wr_th1) th1_reg <= I_BUS.wdata;
            if (wr_timer2_reload_low) rc2_reg[7:0] <= I_BUS.wdata;
            if (wr_timer2_reload_high) rc2_reg[15:8] <= I_BUS.wdata;
        end
    end

    // Timebase and timers.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            m0_cnt_reg  <= 4'h0;
            m2_cnt_reg  <= 2'h0;
            st_reg      <= 1'b0;
            t1_cnt_reg  <= SPBS_BYTE_RST;
            t1_half_reg <= 1'b0;
            t2_cnt_reg  <= SPBS_RC2_RST;
        end else begin
            m0_cnt_reg <= m0_cnt_next;
            m2_cnt_reg <= m2_tick ? 2'h0 : m2_cnt_reg + 2'h1;
            st_reg     <= !st_reg;
            if (m0_tick) t1_cnt_reg <= t1_ovf ? th1_reg : t1_cnt_reg + 8'h01;
            if (t1_ovf) t1_half_reg <= !t1_half_reg;
            // A stopped generator follows the preset, so the first period after
            // enabling is the programmed one rather than a full 16-bit wrap.
            if (!t2_run) begin
                t2_cnt_reg <= rc2_reg;
            end else if (st_reg) begin
                t2_cnt_reg <= t2_ovf ? rc2_reg : t2_cnt_reg + 16'h0001;  // R18
            end
        end
    end

    // Frame engines and pins.
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            tx_state_reg <= SPBS_ST_IDLE;
            rx_state_reg <= SPBS_ST_IDLE;
            {tx_shift_reg, rx_shift_reg, rbuf_reg, rdata_reg} <= {4{SPBS_BYTE_RST}};
            {tx_cnt_reg, rx_cnt_reg, tx_div_reg, rx_div_reg} <= 14'h0000;
            {tx_pend_reg, rx_ninth_reg, s7_reg, s8_reg} <= 4'h0;
            {tx_line_reg, txd_reg, rxd_out_reg, rxd_oe_n_reg} <= 4'hF;
            {rxd_meta_reg, rxd_sync_reg, rxd_prev_reg} <= 3'h7;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= wr_serial_buffer ? I_BUS.wdata : tx_shift_next;      // R21
            tx_pend_reg  <= wr_serial_buffer || (tx_pend_reg && !(tx_step &&
                            tx_state_reg == SPBS_ST_IDLE));
            tx_cnt_reg   <= tx_cnt_next;
            tx_line_reg  <= tx_line_next;
            tx_div_reg   <= tx_tick16 ? tx_div_reg + 4'h1 : tx_div_reg;  // R10
            rx_state_reg <= rx_state_next;
            rx_shift_reg <= rx_shift_next;
            rx_cnt_reg   <= rx_cnt_next;
            rx_ninth_reg <= rx_ninth_next;
            rx_div_reg   <= rx_start ? 4'h0 : (rx_tick16 ? rx_div_reg + 4'h1 : rx_div_reg);
            if (rx_tick16 && rx_div_reg == SPBS_SAMP_A) s7_reg <= rxd_sync_reg;
            if (rx_tick16 && rx_div_reg == SPBS_SAMP_B) s8_reg <= rxd_sync_reg;
            if (rx_load) rbuf_reg <= rx_shift_reg;
            rxd_meta_reg <= I_RXD;
            rxd_sync_reg <= rxd_meta_reg;
            rxd_prev_reg <= rxd_sync_reg;
            txd_reg      <= is_shift ? sclk_next : tx_line_next;
            rxd_out_reg  <= tx_line_next;
            rxd_oe_n_reg <= !(is_shift && tx_state_next != SPBS_ST_IDLE);
            rdata_reg    <= I_BUS.rd ? rd_val : SPBS_BYTE_RST;
        end
    end

    assign O_RDATA    = rdata_reg;
    assign O_TXD      = txd_reg;
    assign O_RXD_OUT  = rxd_out_reg;
    assign O_RXD_OE_N = rxd_oe_n_reg;
    assign O_TX_DONE  = ti_reg;
    assign O_RX_DONE  = ri_reg;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);

    sequence s_stop_vote;
        rx_state_reg == SPBS_ST_STOP && ren_reg && rx_decide;
    endsequence
    property p_mode_shift_no_start;
        is_shift |-> tx_state_reg != SPBS_ST_START && rx_state_reg != SPBS_ST_START;
    endproperty
    a_mode_shift_no_start: assert property (p_mode_shift_no_start) else $error("start in shift"); // R1
    property p_nine_filter;
        s_stop_vote and (is_nine(mode_reg) && sm2_reg && !rx_ninth_reg) |=> $stable(rbuf_reg);
    endproperty
    a_nine_filter: assert property (p_nine_filter) else $error("filtered frame loaded"); // R2
    property p_stop_filter;
        s_stop_vote and (mode_reg == SPBS_MODE_8VAR && sm2_reg && !maj) |=> !$rose(ri_reg) || $past(wr_serial_control_status);
    endproperty
    a_stop_filter: assert property (p_stop_filter) else $error("bad stop accepted"); // R3
    property p_ren_gate;
        !ren_reg |=> rx_state_reg == SPBS_ST_IDLE;
    endproperty
    a_ren_gate: assert property (p_ren_gate) else $error("receive while disabled"); // R5
    property p_ninth_out;
        (tx_state_reg == SPBS_ST_NINTH) && $past(tx_state_reg) != SPBS_ST_NINTH |-> O_TXD == $past(tb8_reg);
    endproperty
    a_ninth_out: assert property (p_ninth_out) else $error("ninth bit wrong"); // R6
    property p_tx_flag;
        (tx_state_reg == SPBS_ST_STOP) && $past(tx_state_reg) != SPBS_ST_STOP |-> ti_reg;
    endproperty
    a_tx_flag: assert property (p_tx_flag) else $error("stop without done flag"); // R8
    property p_rx_flag;
        s_stop_vote and (!ri_reg && !sm2_reg) |=> ri_reg && rb8_reg == $past(rb8_in);
    endproperty
    a_rx_flag: assert property (p_rx_flag) else $error("receive flag missed"); // R9
    property p_m0_rate;
        m0_tick |=> !m0_tick [*8] ##4 m0_tick;
    endproperty
    a_m0_rate: assert property (p_m0_rate) else $error("shift rate wrong"); // R12
    property p_m2_rate;
        (m2_tick && !rate_double_bit_reg) ##1 !rate_double_bit_reg [*4] |->
            m2_tick && !$past(m2_tick) && !$past(m2_tick, 2) && !$past(m2_tick, 3);
    endproperty
    a_m2_rate: assert property (p_m2_rate) else $error("fixed rate wrong"); // R13
    property p_t2_reload;
        t2_ovf && !wr_timer2_reload_low && !wr_timer2_reload_high |=> t2_cnt_reg == $past(rc2_reg);
    endproperty
    a_t2_reload: assert property (p_t2_reload) else $error("timer 2 reload wrong"); // R18
endmodule

//--- test/spbs_remote.sv
/*
 * Remote serial party: sends asynchronous frames to the port and samples
 * the frames that the port transmits.
 * Assumes bit lengths are given in cycles of the 8 ns oscillator clock.
 */
`timescale 1ns/1ps
module spbs_remote (
    // Serial pins
    input  wire logic i_txd,
    output logic      o_rxd
);
    // The line rests high between frames, as a pulled-up line would.
    initial o_rxd = 1'b1;

    // Start bit, then n bits LSB first, the last of them being the stop bit.
    task automatic send(input logic [10:0] bits, input int n, input int bl);
        o_rxd = 1'b0;
        #(bl * 8);
        for (int i = 0; i < n; i++) begin
            o_rxd = bits[i];
            #(bl * 8);
        end
        o_rxd = 1'b1;
    endtask

    // Samples the nine bits after the start bit in the middle of each bit.
    task automatic grab(input int bl, output logic [8:0] got);
        @(negedge i_txd);
        #(bl * 4);
        for (int i = 0; i < 9; i++) begin
            #(bl * 8);
            got[i] = i_txd;
        end
    endtask
endmodule

//--- test/spbs_bench.sv
/*
 * Self-checking bench of the serial port block: register access, bit rates,
 * transmit framing and receive filtering.
 * Assumes the remote party model and the design package are compiled first.
 */
`timescale 1ns/1ps
module spbs_bench;
    import spbs_pkg::*;
    logic             clk;
    logic             rst_n;
    spbs_bus_req_type bus;
    logic [7:0]       rdata;
    logic             rxd;
    logic             txd;
    logic             rxd_out;
    logic             rxd_oe_n;
    logic             tx_done;
    logic             rx_done;
    logic [8:0]       got;
    int               n_mismatch;
    int               cmp_count;
    int               cyc;
    logic [7:0]       r_power_and_rate_control [5] = '{8'h80, 8'h00, 8'h80, 8'h00, 8'h00};
    logic [7:0]       r_t2   [5] = '{8'h00, 8'h00, 8'h00, 8'h14, 8'h00};
    logic [7:0]       r_serial_control_status [5] = '{8'h88, 8'h80, 8'h40, 8'h40, 8'h00};
    logic [7:0]       r_data [5] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h96};
    int               r_nb   [5] = '{10, 10, 9, 9, 8};
    int               r_bl   [5] = '{32, 64, 192, 64, 12};
    logic             r_nin  [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

    spbs_top DUT (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_BUS(bus), .O_RDATA(rdata),
        .I_RXD(rxd), .O_RXD_OUT(rxd_out), .O_RXD_OE_N(rxd_oe_n), .O_TXD(txd),
        .O_TX_DONE(tx_done), .O_RX_DONE(rx_done));
    spbs_remote rem (.i_txd(txd), .o_rxd(rxd));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 check({8'h00, rdata}, {8'h00, exp});
    endtask

    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Counts cycles from the first low on the pin to the done flag, so that
    // the bit rate and the flag moment are checked together.
    task automatic tx_run(input logic [7:0] d, input int nb, input int bl, input logic nin);
        wr(SPBS_ADDR_SERIAL_BUFFER, d);
        fork
            if (nb > 8) rem.grab(bl, got);
            begin
                do begin @(posedge clk); #1; end while (txd !== 1'b0);
                if (nb == 8) check({14'h0000, rxd_oe_n, rxd_out}, {14'h0000, 1'b0, d[0]});
                cyc = 0;
                do begin @(posedge clk); #1; cyc++; end while (tx_done !== 1'b1);
            end
        join
        check(cyc[15:0], nb * bl);
        if (nb > 8) check({7'h00, got}, {7'h00, nin, d});
        // Let the stop bit run out before the next test changes the mode.
        repeat (bl) @(posedge clk);
        $display("tx frame %h done", d);
    endtask

    task automatic rx_expect(input logic [10:0] bits, input int n, input int bl, input logic f);
        rem.send(bits, n, bl);
        repeat (8) @(posedge clk);
        #1 check({15'h0000, rx_done}, {15'h0000, f});
    endtask

    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        bus = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(SPBS_ADDR_POWER_AND_RATE_CONTROL, 8'h00);
        rd(SPBS_ADDR_SERIAL_CONTROL_STATUS, 8'h00);
        rd(8'h00, 8'h00);
        wr(SPBS_ADDR_TH1, 8'hFF);
        wr(SPBS_ADDR_TIMER2_RELOAD_LOW, 8'hFE);
        wr(SPBS_ADDR_TIMER2_RELOAD_HIGH, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            wr(SPBS_ADDR_POWER_AND_RATE_CONTROL, r_power_and_rate_control[i]);
            wr(SPBS_ADDR_TIMER2_CONTROL, r_t2[i]);
            wr(SPBS_ADDR_SERIAL_CONTROL_STATUS, r_serial_control_status[i]);
            tx_run(r_data[i], r_nb[i], r_bl[i], r_nin[i]);
        end
        $display("transmit tests done");
        wr(SPBS_ADDR_POWER_AND_RATE_CONTROL, 8'h80);
        wr(SPBS_ADDR_TIMER2_CONTROL, 8'h00);
        wr(SPBS_ADDR_SERIAL_CONTROL_STATUS, 8'hB0);
        rx_expect({2'b10, 8'h3C}, 10, 32, 1'b0);
        rx_expect({2'b11, 8'h5A}, 10, 32, 1'b1);
        rd(SPBS_ADDR_SERIAL_BUFFER, 8'h5A);
        rd(SPBS_ADDR_SERIAL_CONTROL_STATUS, 8'hB5);
        wr(SPBS_ADDR_SERIAL_CONTROL_STATUS, 8'h80);
        rx_expect({2'b11, 8'h66}, 10, 32, 1'b0);
        wr(SPBS_ADDR_TIMER2_CONTROL, 8'h34);
        wr(SPBS_ADDR_SERIAL_CONTROL_STATUS, 8'h70);
        rx_expect({2'b00, 8'hA5}, 9, 64, 1'b0);
        wr(SPBS_ADDR_SERIAL_CONTROL_STATUS, 8'h50);
        rx_expect({2'b01, 8'hA5}, 9, 64, 1'b1);
        rd(SPBS_ADDR_SERIAL_BUFFER, 8'hA5);
        rd(SPBS_ADDR_SERIAL_CONTROL_STATUS, 8'h55);
        $display("receive tests done");
        report_and_stop();
    end

    initial begin
        #400000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
